// File: cjch_handler.sv
// Command handler for offset and enable sub-functions of function 0x46
`timescale 1ns/100ps
module cjch_handler
  import cjch_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Request byte stream, frame already checked
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic rx_last,
  // Response byte stream
  output logic tx_valid,
  output logic [7:0] tx_data,
  output logic tx_last,
  input wire logic tx_ready,
  // Compensation state to measurement path
  output logic comp_en
);
  cjch_store_if st ();
  cjch_state_t state_r, state_nxt;
  logic [7:0] req_r [CJCH_REQ_MAX];
  logic [7:0] req_nxt [CJCH_REQ_MAX];
  logic [7:0] rsp_r [CJCH_RSP_MAX];
  logic [7:0] rsp_nxt [CJCH_RSP_MAX];
  logic [2:0] cnt_r, cnt_nxt;
  logic [2:0] len_r, len_nxt;
  logic en_r, en_nxt;
  logic [7:0] tx_data_nxt;
  logic exec_r, exec_nxt;
  logic sel_ok;
  logic [3:0] sel_idx;

  cjch_store u_store (
    .clk(clk),
    .rst_n(rst_n),
    .st(st)
  );

  always_comb begin
    sel_ok = (req_r[3] == CJCH_SEL_TOTAL) ||
             (req_r[3] >= CJCH_SEL_CH0 && req_r[3] <= CJCH_SEL_CH7);
    sel_idx = (req_r[3] == CJCH_SEL_TOTAL) ? 4'h0 : {1'b0, req_r[3][2:0]} + 4'h1;
  end

  // Store access, write only in the first EXEC cycle
  always_comb begin
    st.idx = sel_idx;
    st.wdata = {req_r[4], req_r[5]};
    st.we = (state_r == CJCH_EXEC) && !exec_r && req_r[2] == CJCH_SUB_WR_OFS &&
            sel_ok && cnt_r == 3'd6;
  end

  // Next state, collect, decide and serialise
  always_comb begin
    state_nxt = state_r;
    req_nxt = req_r;
    rsp_nxt = rsp_r;
    cnt_nxt = cnt_r;
    len_nxt = len_r;
    en_nxt = en_r;
    exec_nxt = 1'b0;
    tx_data_nxt = tx_data;
    case (state_r)
      CJCH_IDLE, CJCH_RECV: begin
        if (rx_valid) begin
          if (cnt_r < 3'(CJCH_REQ_MAX)) begin
            req_nxt[cnt_r] = rx_data;
            cnt_nxt = cnt_r + 3'd1;
          end
          state_nxt = rx_last ? CJCH_EXEC : CJCH_RECV;
        end
      end
      CJCH_EXEC: begin
        // Two cycles: first writes, second uses registered read data
        exec_nxt = 1'b1;
        rsp_nxt[0] = req_r[0];
        rsp_nxt[1] = req_r[1];
        rsp_nxt[2] = req_r[2];
        len_nxt = 3'd4;
        if (exec_r) begin
          state_nxt = CJCH_SEND;
          if (req_r[1] != CJCH_FUNC) begin
            rsp_nxt[1] = CJCH_FUNC_EXC;
            rsp_nxt[2] = CJCH_EXC_FUNC;
            len_nxt = 3'd3;
          end else begin
            case (req_r[2])
              CJCH_SUB_RD_OFS: begin
                if (cnt_r == 3'd4 && sel_ok) begin
                  rsp_nxt[3] = st.rdata[15:8];
                  rsp_nxt[4] = st.rdata[7:0];
                  len_nxt = 3'd5;
                end else begin
                  rsp_nxt[1] = CJCH_FUNC_EXC;
                  rsp_nxt[2] = CJCH_EXC_DATA;
                  len_nxt = 3'd3;
                end
              end
              CJCH_SUB_WR_OFS: begin
                rsp_nxt[3] = (cnt_r == 3'd6 && sel_ok) ? CJCH_STAT_OK : CJCH_STAT_ERR;
              end
              CJCH_SUB_RD_EN: begin
                if (cnt_r == 3'd4 && req_r[3] == CJCH_RESERVED) begin
                  rsp_nxt[3] = en_r ? CJCH_EN_ON : CJCH_EN_OFF;
                end else begin
                  rsp_nxt[1] = CJCH_FUNC_EXC;
                  rsp_nxt[2] = CJCH_EXC_DATA;
                  len_nxt = 3'd3;
                end
              end
              // Enable set, bad setting gives nonzero status
              CJCH_SUB_WR_EN: begin
                if (cnt_r == 3'd5 && req_r[3] == CJCH_RESERVED &&
                    (req_r[4] == CJCH_EN_ON || req_r[4] == CJCH_EN_OFF)) begin
                  en_nxt = req_r[4][0];
                  rsp_nxt[3] = CJCH_STAT_OK;
                end else begin
                  rsp_nxt[3] = CJCH_STAT_ERR;
                end
              end
              default: begin
                rsp_nxt[1] = CJCH_FUNC_EXC;
                rsp_nxt[2] = CJCH_EXC_FUNC;
                len_nxt = 3'd3;
              end
            endcase
          end
          cnt_nxt = 3'd0;
          tx_data_nxt = rsp_nxt[0];
        end
      end
      CJCH_SEND: begin
        if (tx_ready) begin
          if (cnt_r + 3'd1 == len_r) begin
            state_nxt = CJCH_IDLE;
            cnt_nxt = 3'd0;
          end else begin
            cnt_nxt = cnt_r + 3'd1;
            tx_data_nxt = rsp_r[cnt_r + 3'd1];
          end
        end
      end
      default: begin
        state_nxt = CJCH_IDLE;
        cnt_nxt = 3'd0;
      end
    endcase
  end

  // Register all handler state
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_r <= CJCH_IDLE;
      cnt_r <= 3'd0;
      len_r <= 3'd0;
      en_r <= CJCH_EN_RST;
      exec_r <= 1'b0;
      tx_data <= 8'h00;
      for (int i = 0; i < CJCH_REQ_MAX; i++) begin
        req_r[i] <= 8'h00;
      end
      for (int i = 0; i < CJCH_RSP_MAX; i++) begin
        rsp_r[i] <= 8'h00;
      end
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      len_r <= len_nxt;
      en_r <= en_nxt;
      exec_r <= exec_nxt;
      tx_data <= tx_data_nxt;
      req_r <= req_nxt;
      rsp_r <= rsp_nxt;
    end
  end

  // Handshake outputs
  always_comb begin
    tx_valid = (state_r == CJCH_SEND);
    tx_last = tx_valid && (cnt_r + 3'd1 == len_r);
    comp_en = en_r;
  end

  exc_len_a: assert property (@(posedge clk) disable iff (!rst_n)
    (tx_valid && cnt_r == 3'd1 && tx_data == CJCH_FUNC_EXC) |-> len_r == 3'd3)
    else $error("exception frame not three bytes");
  // Good offset read gives five bytes
  rd_len_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state_r == CJCH_EXEC && exec_r && req_r[1] == CJCH_FUNC &&
     req_r[2] == CJCH_SUB_RD_OFS && cnt_r == 3'd4 && sel_ok) |=> len_r == 3'd5)
    else $error("offset read reply length wrong");
  // Store written only on offset write sub-function with valid selector
  wr_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
    st.we |-> (sel_ok && req_r[2] == CJCH_SUB_WR_OFS))
    else $error("store written without valid write");
  en_set_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state_r == CJCH_EXEC && exec_r && req_r[1] == CJCH_FUNC &&
     req_r[2] == CJCH_SUB_WR_EN && cnt_r == 3'd5 && req_r[3] == 8'h00 &&
     req_r[4] == CJCH_EN_ON) |=> comp_en)
    else $error("enable not applied");
  en_keep_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state_r == CJCH_EXEC && exec_r && req_r[4] != CJCH_EN_ON &&
     req_r[4] != CJCH_EN_OFF) |=> $stable(comp_en))
    else $error("bad setting changed enable");
  // Reply starts two cycles after the first EXEC cycle
  exec_time_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state_r == CJCH_EXEC && !exec_r) |-> ##2 tx_valid)
    else $error("reply not started in time");
endmodule

// File: cjch_pkg.sv
// Package: codes, frame layout and reset values for the offset command handler
package cjch_pkg;
  localparam logic [7:0] CJCH_FUNC = 8'h46;
  localparam logic [7:0] CJCH_FUNC_EXC = 8'hc6;
  localparam logic [7:0] CJCH_SUB_RD_OFS = 8'h2b;
  localparam logic [7:0] CJCH_SUB_WR_OFS = 8'h2c;
  localparam logic [7:0] CJCH_SUB_RD_EN = 8'h2d;
  localparam logic [7:0] CJCH_SUB_WR_EN = 8'h2e;
  localparam logic [7:0] CJCH_SEL_TOTAL = 8'h00;
  localparam logic [7:0] CJCH_SEL_CH0 = 8'h80;
  localparam logic [7:0] CJCH_SEL_CH7 = 8'h87;
  localparam logic [7:0] CJCH_EN_OFF = 8'h00;
  localparam logic [7:0] CJCH_EN_ON = 8'h01;
  localparam logic [7:0] CJCH_RESERVED = 8'h00;
  localparam logic [7:0] CJCH_STAT_OK = 8'h00;
  localparam logic [7:0] CJCH_STAT_ERR = 8'h01;
  localparam logic [7:0] CJCH_EXC_FUNC = 8'h01;
  localparam logic [7:0] CJCH_EXC_DATA = 8'h03;
  localparam logic [15:0] CJCH_OFS_RST = 16'h0000;
  localparam logic CJCH_EN_RST = 1'b1;
  localparam int CJCH_NCH = 9;
  localparam int CJCH_REQ_MAX = 6;
  localparam int CJCH_RSP_MAX = 5;
  typedef enum {CJCH_IDLE, CJCH_RECV, CJCH_EXEC, CJCH_SEND} cjch_state_t;
endpackage

// File: cjch_store_if.sv
// Interface: offset store access between handler and store
`timescale 1ns/100ps
interface cjch_store_if;
  logic [3:0] idx;
  logic we;
  logic [15:0] wdata;
  logic [15:0] rdata;
  modport ctl (output idx, output we, output wdata, input rdata);
  modport mem (input idx, input we, input wdata, output rdata);
endinterface

// File: cjch_store.sv
// Offset store: total offset plus eight per-channel offsets
`timescale 1ns/100ps
module cjch_store
  import cjch_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Access port
  cjch_store_if.mem st
);
  logic [15:0] ofs_r [CJCH_NCH];
  logic [15:0] ofs_nxt [CJCH_NCH];

  // Next values: only the addressed word changes
  always_comb begin
    for (int i = 0; i < CJCH_NCH; i++) begin
      ofs_nxt[i] = ofs_r[i];
    end
    if (st.we && st.idx < 4'(CJCH_NCH)) begin
      ofs_nxt[st.idx] = st.wdata;
    end
  end

  // Register the array
  always_ff @(posedge clk) begin
    for (int i = 0; i < CJCH_NCH; i++) begin
      ofs_r[i] <= rst_n ? ofs_nxt[i] : CJCH_OFS_RST;
    end
  end

  // Read port, registered so data stays glitch free
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st.rdata <= CJCH_OFS_RST;
    end else begin
      st.rdata <= (st.idx < 4'(CJCH_NCH)) ? ofs_r[st.idx] : CJCH_OFS_RST;
    end
  end
endmodule

// File: cjch_host.sv
// Host model: sends request frames and collects reply bytes
`timescale 1ns/100ps
module cjch_host (
  // Clock
  input wire logic clk,
  // Request stream to handler
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic rx_last,
  // Reply stream from handler
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_last,
  output logic tx_ready
);
  // Set by the bench to make the sink stall every other cycle
  logic slow;
  initial begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
    rx_last = 1'b0;
    tx_ready = 1'b0;
  end
  // whole frames only, first byte in the top bits
  task automatic xfer(input logic [47:0] req, input int n,
                      output logic [39:0] rsp, output int m);
    bit last_seen;
    m = 0;
    last_seen = 1'b0;
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      rx_valid <= 1'b1;
      rx_data <= req[47-8*i -: 8];
      rx_last <= (i == n - 1);
    end
    @(posedge clk);
    rx_valid <= 1'b0;
    rx_last <= 1'b0;
    rx_data <= ~rx_data;  // Idle line never shows the last byte
    // Bounded wait; a stalled sink must not lose or repeat bytes
    for (int w = 0; w < 40 && m < 5; w++) begin
      @(posedge clk);
      if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
        rsp[39-8*m -: 8] = tx_data;
        m++;
        if (tx_last === 1'b1) begin
          last_seen = 1'b1;
          break;
        end
      end
      tx_ready <= slow ? ~tx_ready : 1'b1;
    end
    tx_ready <= 1'b0;
    // A reply without its end marker shows up as a length mismatch
    if (!last_seen) m = m + 8;
  endtask
endmodule

// File: testbench.sv
// Testbench: offset and enable command scenarios against the handler
`timescale 1ns/100ps
module testbench;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic rx_valid, rx_last, tx_valid, tx_last, tx_ready, comp_en;
  logic [7:0] rx_data, tx_data;
  int mismatches = 0;
  int checks_done = 0;
  int cycles = 0;
  cjch_handler uut (.clk(clk), .rst_n(rst_n), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_last(rx_last), .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last),
    .tx_ready(tx_ready), .comp_en(comp_en));
  cjch_host host (.clk(clk), .rx_valid(rx_valid), .rx_data(rx_data), .rx_last(rx_last),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready));
  // 100 MHz clock
  always #5 clk = ~clk;
  // Hang guard, far above the few hundred cycles needed
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      mismatches++;
      final_report();
    end
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("FAIL at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One frame out, reply length and bytes compared
  task automatic run(input logic [47:0] r, input int n, input logic [39:0] e, input int em);
    logic [39:0] rsp;
    int m;
    host.xfer(r, n, rsp, m);
    check(16'(m), 16'(em));
    for (int i = 0; i < em && i < m; i++) begin
      check({8'h00, rsp[39-8*i -: 8]}, {8'h00, e[39-8*i -: 8]});
    end
  endtask
  task automatic t_reset;
    check({15'h0000, tx_valid}, 16'h0000);
    check({15'h0000, comp_en}, 16'h0001);
    // Total offset reads zero after reset
    run(48'h01462b000000, 4, 40'h01462b0000, 5);
    $display("test reset done");
  endtask
  // Every selector written, then read back through a stalling sink
  task automatic t_offsets;
    logic [7:0] sel;
    // Total offset, negative value
    run(48'h01462c00fe0c, 6, 40'h01462c0000, 4);
    for (int i = 0; i < 8; i++) begin
      sel = 8'h80 + 8'(i);
      // Per-channel write, status zero
      run({24'h01462c, sel, 8'hc0 | 8'(i), 8'h30 + 8'(i)}, 6, 40'h01462c0000, 4);
    end
    host.slow = 1'b1;
    for (int i = 0; i < 8; i++) begin
      sel = 8'h80 + 8'(i);
      // High byte first
      run({24'h01462b, sel, 16'h0000}, 4, {24'h01462b, 8'hc0 | 8'(i), 8'h30 + 8'(i)}, 5);
    end
    // Total kept apart from channels
    run(48'h7b462b000000, 4, 40'h7b462bfe0c, 5);
    host.slow = 1'b0;
    $display("test offsets done");
  endtask
  task automatic t_faults;
    // Selector just past channel seven
    run(48'h01462b880000, 4, 40'h01c6030000, 3);
    // Write to undefined selector fails by status
    run(48'h01462c7f1234, 6, 40'h01462c0100, 4);
    // Wrong length on a read
    run(48'h01462b800000, 5, 40'h01c6030000, 3);
    // Unknown function and unknown sub-function
    run(48'h7b032b000000, 4, 40'h7bc6010000, 3);
    run(48'h01462f000000, 4, 40'h01c6010000, 3);
    // Failed write left channel zero untouched
    run(48'h01462b800000, 4, 40'h01462bc030, 5);
    $display("test faults done");
  endtask
  task automatic t_enable;
    // Disable, reply status zero
    run(48'h01462e000000, 5, 40'h01462e0000, 4);
    check({15'h0000, comp_en}, 16'h0000);
    // Query reports disabled
    run(48'h01462d000000, 4, 40'h01462d0000, 4);
    // Undefined setting fails, state kept
    run(48'h01462e000200, 5, 40'h01462e0100, 4);
    check({15'h0000, comp_en}, 16'h0000);
    // Nonzero reserved byte on a set fails, state kept
    run(48'h01462e010100, 5, 40'h01462e0100, 4);
    check({15'h0000, comp_en}, 16'h0000);
    // Nonzero reserved byte on query
    run(48'h01462d010000, 4, 40'h01c6030000, 3);
    // Enable again
    run(48'h01462e000100, 5, 40'h01462e0000, 4);
    check({15'h0000, comp_en}, 16'h0001);
    // Query reports enabled
    run(48'h01462d000000, 4, 40'h01462d0100, 4);
    $display("test enable done");
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    host.slow = 1'b0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_offsets();
    t_faults();
    t_enable();
    final_report();
  end
endmodule
